// *** hdl/scc_strap_config.sv ***
// Strap capture, clock-mode phase logic, DRAM parity and reset outputs.
`timescale 1ns/1ns
// Contract
// - Double-clock mode: CPU clock drives logic, PCI clock only gives phase.
// - Single-clock mode: PCI clock ignored, no phase recognition needed.
// - All state machines run on the CPU clock in both modes.
// - Clock strap low selects double-clock, high selects single-clock.
// - Cache strap high: shared pins are cache chip selects, no parity.
// - Cache strap low: shared pins carry DRAM parity, check reads, generate writes.
// - Read parity error in parity mode raises NMI toward the CPU.
// - Error pin strapped high works as PCI parity error with checking.
// - Error pin strapped low drives memory buffer direction.
// - Active-low system reset mirrors active-high reset with opposite polarity.
// - Software parity-check disable at index 1Bh blocks the interrupt.
// - RTC strap high enables internal RTC, low makes pin external chip select.
module scc_strap_config
  import scc_pkg::*;
#(
  parameter int RESET_HOLD = SCC_RESET_HOLD
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clock_mode_strap_i,
  input wire logic cache_select_strap_i,
  input wire logic pci_error_or_dir_pin_i,
  input wire logic rtc_enable_strap_i,
  input wire logic pci_clock_in_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_index_i,
  input wire logic [7:0] cfg_data_i,
  input wire logic dram_rd_i,
  input wire logic dram_wr_i,
  input wire logic [SCC_DATA_W-1:0] dram_wdata_i,
  input wire logic [SCC_DATA_W-1:0] dram_rdata_i,
  input wire logic [SCC_LANES-1:0] dram_parity_lines_i,
  input wire logic [SCC_LANES-1:0] cache_cs_req_i,
  input wire logic pci_perr_req_i,
  input wire logic mem_read_dir_i,
  output logic [SCC_LANES-1:0] shared_pins_o,
  output logic [SCC_LANES-1:0] shared_pins_oe_o,
  output logic pci_error_or_dir_pin_o,
  output logic pci_error_or_dir_pin_oe_o,
  output logic rtc_cs_n_o,
  output logic rtc_cs_oe_o,
  output logic rtc_internal_o,
  output logic double_clock_o,
  output logic pci_phase_o,
  output logic nmi_o,
  output logic system_reset_out_o,
  output logic system_reset_out_n_o,
  input wire logic rtc_cs_req_i
);

  localparam int HOLD_W = $clog2(RESET_HOLD + 1);
  localparam logic [HOLD_W-1:0] HOLD_MAX = HOLD_W'(RESET_HOLD);

  scc_cfg_t cfg_reg;
  logic captured_reg;
  logic [HOLD_W-1:0] hold_reg;
  logic par_dis_reg;
  logic [2:0] pci_sync_reg;
  logic pci_phase_reg;
  logic nmi_reg;
  logic [SCC_LANES-1:0] shared_reg;
  logic [SCC_LANES-1:0] shared_oe_reg;
  logic err_pin_reg;
  logic err_oe_reg;
  logic rtc_cs_reg;
  logic rtc_oe_reg;
  logic system_reset_out_reg;
  logic system_reset_out_n_reg;
  logic rd_pend_reg;
  logic [SCC_DATA_W-1:0] rdata_reg;
  logic [SCC_LANES-1:0] rpar_reg;
  scc_strap_t strap_pins;
  scc_strap_t strap_meta_reg;
  scc_strap_t strap_mid_reg;
  scc_strap_t strap_last_reg;
  logic pci_level_reg;

  // Strap levels are decoded once; low clock strap means double-clock.
  // Straps are board pins; the three flops have no reset, so they keep sampling
  // while reset is held and the level is already settled at release.
  assign strap_pins = {clock_mode_strap_i, cache_select_strap_i, pci_error_or_dir_pin_i, rtc_enable_strap_i};
  always_ff @(posedge sys_clk_i)
  begin
    strap_meta_reg <= strap_pins;
    strap_mid_reg <= strap_meta_reg;
    strap_last_reg <= strap_mid_reg;
  end
  wire strap_settled = (strap_mid_reg == strap_last_reg);

  scc_cfg_t strap_cfg;
  assign strap_cfg.double_clock = (strap_last_reg.clock_mode_strap == SCC_STRAP_LOW);
  assign strap_cfg.parity_mode = (strap_last_reg.cache_select_strap == SCC_STRAP_LOW);
  assign strap_cfg.mem_dir_mode = (strap_last_reg.pci_error_or_dir_pin == SCC_STRAP_LOW);
  assign strap_cfg.rtc_internal = (strap_last_reg.rtc_enable_strap == SCC_STRAP_HIGH);

  // Reset extension keeps the system reset out asserted while straps settle.
  wire hold_done = (hold_reg == HOLD_MAX);

  // Straps are taken on the first clock after release at which the second and
  // third flops agree, while system reset is still driven, so the asynchronous
  // reset never loads a pin value.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg_reg <= '0;
      captured_reg <= 1'b0;
      hold_reg <= '0;
    end
    else
    begin
      if (!captured_reg && strap_settled)
      begin
        cfg_reg <= strap_cfg;
        captured_reg <= 1'b1;
      end
      if (!hold_done)
        hold_reg <= hold_reg + HOLD_W'(1);
    end
  end

  // Both reset pins come from one condition so their timing is identical.
  wire system_reset_out_next = !hold_done;
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      system_reset_out_reg <= 1'b1;
      system_reset_out_n_reg <= 1'b0;
    end
    else
    begin
      system_reset_out_reg <= system_reset_out_next;
      system_reset_out_n_reg <= !system_reset_out_next;
    end
  end

  // Parity-check disable register written through configuration index 1Bh.
  wire par_cfg_hit = cfg_wr_i && (cfg_index_i == SCC_PARITY_CFG_INDEX);
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      par_dis_reg <= 1'b0;
    else if (par_cfg_hit)
      par_dis_reg <= cfg_data_i[SCC_PARITY_DIS_BIT];
  end

  // PCI clock is a foreign signal; three flops, edge once second and third agree.
  // In single-clock mode the phase output is held low and the input unused.
  wire pci_agree = (pci_sync_reg[1] == pci_sync_reg[2]);
  wire pci_rise = pci_agree && pci_sync_reg[2] && !pci_level_reg;
  wire phase_next = cfg_reg.double_clock ? pci_rise : 1'b0;
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pci_sync_reg <= '0;
      pci_level_reg <= 1'b0;
      pci_phase_reg <= 1'b0;
    end
    else
    begin
      pci_sync_reg <= {pci_sync_reg[1:0], pci_clock_in_i};
      pci_level_reg <= pci_agree ? pci_sync_reg[2] : pci_level_reg;
      pci_phase_reg <= phase_next;
    end
  end

  // Even parity per byte lane for writes and for checking read data.
  function automatic logic [SCC_LANES-1:0] lane_parity(input logic [SCC_DATA_W-1:0] d);
    logic [SCC_LANES-1:0] p;
    p = '0;
    for (int i = 0; i < SCC_LANES; i++)
      p[i] = ^d[i*SCC_BYTE_W +: SCC_BYTE_W];
    return p;
  endfunction

  wire [SCC_LANES-1:0] wpar = lane_parity(dram_wdata_i);
  wire [SCC_LANES-1:0] rpar_calc = lane_parity(rdata_reg);
  wire par_err = rd_pend_reg && (rpar_calc != rpar_reg);
  wire nmi_set = par_err && cfg_reg.parity_mode && !par_dis_reg;

  // Read data and parity lines are registered, then compared a cycle later.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_pend_reg <= 1'b0;
      rdata_reg <= '0;
      rpar_reg <= '0;
      nmi_reg <= 1'b0;
    end
    else
    begin
      rd_pend_reg <= dram_rd_i && cfg_reg.parity_mode && captured_reg;
      rdata_reg <= dram_rdata_i;
      rpar_reg <= dram_parity_lines_i;
      nmi_reg <= nmi_set;
    end
  end

  // Shared pins: cache selects when strap high, parity lines when low.
  // In parity mode they are driven only during writes and released for reads.
  wire [SCC_LANES-1:0] shared_next = cfg_reg.parity_mode ? wpar : cache_cs_req_i;
  wire [SCC_LANES-1:0] shared_oe_next = (!cfg_reg.parity_mode || dram_wr_i) ? {SCC_LANES{1'b1}} : '0;

  // Error pin is open-drain PCI parity error, or a driven direction output.
  wire err_next = cfg_reg.mem_dir_mode ? mem_read_dir_i : 1'b0;
  wire err_oe_next = cfg_reg.mem_dir_mode ? 1'b1 : pci_perr_req_i;

  // External RTC select exists only when the internal RTC is strapped off.
  wire rtc_cs_next = !rtc_cs_req_i;
  wire rtc_oe_next = !cfg_reg.rtc_internal;

  // Pins stay released until the straps are captured and reset extension ends,
  // so the board resistors are not fought during sampling.
  wire pins_live = captured_reg && hold_done;
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      shared_reg <= SCC_CS_IDLE;
      shared_oe_reg <= '0;
      err_pin_reg <= 1'b0;
      err_oe_reg <= 1'b0;
      rtc_cs_reg <= 1'b1;
      rtc_oe_reg <= 1'b0;
    end
    else
    begin
      shared_reg <= shared_next;
      shared_oe_reg <= pins_live ? shared_oe_next : '0;
      err_pin_reg <= err_next;
      err_oe_reg <= pins_live && err_oe_next;
      rtc_cs_reg <= rtc_cs_next;
      rtc_oe_reg <= pins_live && rtc_oe_next;
    end
  end

  assign shared_pins_o = shared_reg;
  assign shared_pins_oe_o = shared_oe_reg;
  assign pci_error_or_dir_pin_o = err_pin_reg;
  assign pci_error_or_dir_pin_oe_o = err_oe_reg;
  assign rtc_cs_n_o = rtc_cs_reg;
  assign rtc_cs_oe_o = rtc_oe_reg;
  assign rtc_internal_o = cfg_reg.rtc_internal;
  assign double_clock_o = cfg_reg.double_clock;
  assign pci_phase_o = pci_phase_reg;
  assign nmi_o = nmi_reg;
  assign system_reset_out_o = system_reset_out_reg;
  assign system_reset_out_n_o = system_reset_out_n_reg;

  // Assertions.
  sequence s_bad_read;
    rd_pend_reg && (rpar_calc != rpar_reg) && cfg_reg.parity_mode && !par_dis_reg;
  endsequence

  property p_reset_twin;
    @(posedge sys_clk_i) disable iff (rst_i) system_reset_out_o != system_reset_out_n_o;
  endproperty
  a_reset_twin: assert property (p_reset_twin) else $error("reset twins not opposite");

  property p_nmi_on_error;
    @(posedge sys_clk_i) disable iff (rst_i) s_bad_read |=> nmi_o;
  endproperty
  a_nmi_on_error: assert property (p_nmi_on_error) else $error("parity error gave no nmi");

  property p_nmi_blocked;
    @(posedge sys_clk_i) disable iff (rst_i) (par_dis_reg || !cfg_reg.parity_mode) |=> !nmi_o;
  endproperty
  a_nmi_blocked: assert property (p_nmi_blocked) else $error("nmi while parity off");

  property p_single_no_phase;
    @(posedge sys_clk_i) disable iff (rst_i) !cfg_reg.double_clock |=> !pci_phase_o;
  endproperty
  a_single_no_phase: assert property (p_single_no_phase) else $error("phase in single mode");

  property p_double_phase;
    @(posedge sys_clk_i) disable iff (rst_i) (cfg_reg.double_clock && pci_rise) |=> pci_phase_o;
  endproperty
  a_double_phase: assert property (p_double_phase) else $error("phase edge missed");

  property p_cfg_hold;
    @(posedge sys_clk_i) disable iff (rst_i) captured_reg |=> $stable(cfg_reg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("strap config changed");

  property p_cache_cs;
    @(posedge sys_clk_i) disable iff (rst_i) !cfg_reg.parity_mode |=> shared_pins_o == $past(cache_cs_req_i);
  endproperty
  a_cache_cs: assert property (p_cache_cs) else $error("cache selects wrong");

  property p_dir_pin;
    @(posedge sys_clk_i) disable iff (rst_i) (pins_live && cfg_reg.mem_dir_mode) |=> pci_error_or_dir_pin_oe_o;
  endproperty
  a_dir_pin: assert property (p_dir_pin) else $error("direction pin not driven");

  property p_rtc_pin;
    @(posedge sys_clk_i) disable iff (rst_i) cfg_reg.rtc_internal |=> !rtc_cs_oe_o;
  endproperty
  a_rtc_pin: assert property (p_rtc_pin) else $error("rtc select driven with internal rtc");

  property p_phase_pulse;
    @(posedge sys_clk_i) disable iff (rst_i) pci_phase_o |=> !pci_phase_o;
  endproperty
  a_phase_pulse: assert property (p_phase_pulse) else $error("phase pulse longer than one cycle");

  property p_write_parity;
    @(posedge sys_clk_i) disable iff (rst_i)
      (pins_live && cfg_reg.parity_mode && dram_wr_i)
      |=> (shared_pins_oe_o == {SCC_LANES{1'b1}}) && (shared_pins_o == $past(wpar));
  endproperty
  a_write_parity: assert property (p_write_parity) else $error("write parity not driven");

endmodule

// *** include/scc_pkg.sv ***
// Package for the strap configuration and clock-mode block.
package scc_pkg;
  localparam int SCC_LANES = 4;
  localparam int SCC_BYTE_W = 8;
  localparam int SCC_DATA_W = 32;
  localparam logic SCC_STRAP_LOW = 1'b0;
  localparam logic SCC_STRAP_HIGH = 1'b1;
  localparam int SCC_RESET_HOLD = 16;
  localparam logic [7:0] SCC_PARITY_CFG_INDEX = 8'h1b;
  localparam int SCC_PARITY_DIS_BIT = 0;
  localparam logic [3:0] SCC_CS_IDLE = 4'hf;

  // Captured strap configuration.
  typedef struct packed {
    logic double_clock;
    logic parity_mode;
    logic mem_dir_mode;
    logic rtc_internal;
  } scc_cfg_t;

  // Raw strap levels as seen on the pins.
  typedef struct packed {
    logic clock_mode_strap;
    logic cache_select_strap;
    logic pci_error_or_dir_pin;
    logic rtc_enable_strap;
  } scc_strap_t;
endpackage

// *** tb/scc_board_model.sv ***
// Board model: strap resistors, DRAM parity storage and the PCI clock source.
`timescale 1ns/1ns
module scc_board_model
  import scc_pkg::*;
(
  input wire scc_strap_t fit_i,
  input wire logic [SCC_DATA_W-1:0] rdata_i,
  input wire logic [SCC_LANES-1:0] flip_i,
  output scc_strap_t strap_o,
  output logic [SCC_LANES-1:0] parity_o,
  output logic pci_clk_o
);
  // Resistors hold the chosen levels; the bench picks one per board build.
  assign strap_o = fit_i;
  // Stored even parity per byte; flip models a corrupted DRAM bit.
  assign parity_o = {^rdata_i[31:24], ^rdata_i[23:16], ^rdata_i[15:8], ^rdata_i[7:0]} ^ flip_i;
  // PCI clock runs free at a rate and phase unrelated to the CPU clock.
  initial
  begin
    pci_clk_o = 1'b0;
    #3;
    forever #17 pci_clk_o = ~pci_clk_o;
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the strap configuration block.
`timescale 1ns/1ns
module testbench;
  import scc_pkg::*;
  typedef struct packed {
    scc_strap_t s;
    logic dc;
  } scc_row_t;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  scc_strap_t fit = 4'h0;
  scc_strap_t strap;
  logic cfg_wr = 1'b0;
  logic [7:0] cfg_idx = 8'h00;
  logic [7:0] cfg_dat = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata = 32'h0;
  logic [3:0] flip = 4'h0;
  logic [3:0] par;
  logic perr_req = 1'b1;
  logic [3:0] ccs = 4'h5;
  logic mem_buffer_direction = 1'b1;
  logic rtc_req = 1'b1;
  logic pci_clk;
  logic [3:0] pins, pins_oe;
  logic err_o, err_oe, rtc_n, rtc_oe, rtc_int, dc_o, phase, nmi, srst, srst_n;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int cnt;
  scc_row_t rows [4] = '{'{4'b0000, 1'b1}, '{4'b1111, 1'b0}, '{4'b0101, 1'b1}, '{4'b1010, 1'b0}};

  scc_board_model board (.fit_i(fit), .rdata_i(rdata), .flip_i(flip), .strap_o(strap), .parity_o(par),
    .pci_clk_o(pci_clk));
  scc_strap_config #(.RESET_HOLD(2)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .clock_mode_strap_i(strap.clock_mode_strap), .cache_select_strap_i(strap.cache_select_strap),
    .pci_error_or_dir_pin_i(strap.pci_error_or_dir_pin), .rtc_enable_strap_i(strap.rtc_enable_strap),
    .pci_clock_in_i(pci_clk), .cfg_wr_i(cfg_wr), .cfg_index_i(cfg_idx), .cfg_data_i(cfg_dat),
    .dram_rd_i(rd), .dram_wr_i(wr), .dram_wdata_i(wdata), .dram_rdata_i(rdata), .dram_parity_lines_i(par),
    .cache_cs_req_i(ccs), .pci_perr_req_i(perr_req), .mem_read_dir_i(mem_buffer_direction), .shared_pins_o(pins),
    .shared_pins_oe_o(pins_oe), .pci_error_or_dir_pin_o(err_o), .pci_error_or_dir_pin_oe_o(err_oe),
    .rtc_cs_n_o(rtc_n), .rtc_cs_oe_o(rtc_oe), .rtc_internal_o(rtc_int), .double_clock_o(dc_o),
    .pci_phase_o(phase), .nmi_o(nmi), .system_reset_out_o(srst), .system_reset_out_n_o(srst_n),
    .rtc_cs_req_i(rtc_req));

  // Clock at 100 MHz.
  initial
  begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Resets for two cycles with a new board build, checking outputs in and after reset.
  task automatic do_reset(input scc_strap_t s);
    @(posedge sys_clk_i);
    fit <= s;
    rst_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    chk("reset pins", 32'h0f10, {pins_oe, pins, 3'b000, srst, 3'b000, srst_n});
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    #1;
    chk("reset out", 32'h1, {srst, srst_n});
  endtask

  // One DRAM read; the interrupt pulse stands in the cycle after the edge that follows the take.
  task automatic rd_chk(input logic [3:0] f, input logic exp);
    @(posedge sys_clk_i);
    rd <= 1'b1;
    rdata <= 32'h8001_7f3c;
    flip <= f;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1;
    chk("nmi early", 32'h0, nmi);
    @(posedge sys_clk_i);
    #1;
    chk("nmi", exp, nmi);
    @(posedge sys_clk_i);
    #1;
    chk("nmi width", 32'h0, nmi);
  endtask

  task automatic cfg(input logic [7:0] idx, input logic [7:0] d);
    @(posedge sys_clk_i);
    cfg_wr <= 1'b1;
    cfg_idx <= idx;
    cfg_dat <= d;
    @(posedge sys_clk_i);
    cfg_wr <= 1'b0;
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // A hang is cut short well past the expected run length.
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      test_done();
    end
  end

  initial
  begin
    foreach (rows[i])
    begin
      do_reset(rows[i].s);
      chk("double clock", rows[i].dc, dc_o);
      chk("rtc", {1'b0, rows[i].s.rtc_enable_strap, ~rows[i].s.rtc_enable_strap}, {rtc_int, rtc_oe});
      if (!rows[i].s.rtc_enable_strap)
        chk("rtc select", 32'h0, rtc_n);
      chk("error pin", rows[i].s.pci_error_or_dir_pin ? 32'h2 : 32'h3, {err_oe, err_o});
      if (rows[i].s.cache_select_strap)
        chk("cache selects", 32'hf5, {pins_oe, pins});
      else
      begin
        @(posedge sys_clk_i);
        wr <= 1'b1;
        wdata <= 32'h0103_07ff;
        @(posedge sys_clk_i);
        wr <= 1'b0;
        #1;
        chk("write parity", 32'hfa, {pins_oe, pins});
      end
      rd_chk(4'h4, ~rows[i].s.cache_select_strap);
      cnt = 0;
      repeat (40)
      begin
        @(posedge sys_clk_i);
        #1;
        cnt += phase;
      end
      chk("phase seen", rows[i].dc, cnt != 0);
    end
    // Parity mode: good data, other index ignored, disable, re-enable.
    do_reset(4'h0);
    rd_chk(4'h0, 1'b0);
    rd_chk(4'h1, 1'b1);
    rd_chk(4'h8, 1'b1);
    cfg(8'h1a, 8'h01);
    rd_chk(4'h2, 1'b1);
    cfg(SCC_PARITY_CFG_INDEX, 8'h01);
    rd_chk(4'h2, 1'b0);
    cfg(SCC_PARITY_CFG_INDEX, 8'h00);
    rd_chk(4'h2, 1'b1);
    // Straps moved after capture must not change the configuration.
    @(posedge sys_clk_i);
    fit <= 4'hf;
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk("held config", 32'h2, {dc_o, rtc_int});
    // Direction and external RTC select follow their requests a cycle later.
    @(posedge sys_clk_i);
    mem_buffer_direction <= 1'b0;
    rtc_req <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk("direction follow", 32'h2, {err_oe, err_o});
    chk("rtc deselect", 32'h1, rtc_n);
    // Cache selects follow a new request; a dropped error request releases the pin.
    do_reset(4'hf);
    @(posedge sys_clk_i);
    ccs <= 4'ha;
    perr_req <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk("cache follow", 32'hfa, {pins_oe, pins});
    chk("error release", 32'h0, {err_oe, err_o});
    test_done();
  end
endmodule
